// ---- src/wrsu_top.sv ----
// watchdog and reset-status unit: AXI4-Lite registers, protected control, reset flags
`timescale 1ns/100ps
`default_nettype none
module wrsu_top #(
	parameter int TIMEOUT_BASE = wrsu_pkg::TIMEOUT_BASE_DEF
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic kickStrobe,
	input wire logic safetyLevelFuse,
	input wire logic supplyMonitorFuse,
	input wire logic comparatorBandgapSelect,
	input wire logic adcEnable,
	input wire logic pinResetIn,
	input wire logic supplyDropIn,
	output logic chipResetPulse,
	output logic bandgapPowerOn
);
	wrsu_wdt_if wdt ();

	// ----------------------------------------------------------------
	// reset release and pin synchronisers
	// ----------------------------------------------------------------
	logic rstMeta_reg;
	logic rstN;
	logic [3:0] pinMeta_reg;
	logic [3:0] pinSync_reg;
	logic [1:0] evtPrev_reg;
	logic fuseSafe;
	logic fuseSupply;
	logic pinEdge;
	logic supplyEdge;

	// reset asserts at once but releases through two flops
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rstMeta_reg <= 1'b0;
			rstN <= 1'b0;
		end else begin
			rstMeta_reg <= 1'b1;
			rstN <= rstMeta_reg;
		end
	end

	// fuses and reset-source pins come from outside the clock domain
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			pinMeta_reg <= 4'h0;
			pinSync_reg <= 4'h0;
			evtPrev_reg <= 2'h0;
		end else begin
			pinMeta_reg <= {supplyDropIn, pinResetIn, supplyMonitorFuse, safetyLevelFuse};
			pinSync_reg <= pinMeta_reg;
			evtPrev_reg <= pinSync_reg[3:2];
		end
	end

	assign fuseSafe = pinSync_reg[0];
	assign fuseSupply = pinSync_reg[1];
	assign pinEdge = pinSync_reg[2] && !evtPrev_reg[0];
	assign supplyEdge = pinSync_reg[3] && !evtPrev_reg[1];

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	logic awHeld_reg, awHeld_next;
	logic [7:0] awAddr_reg, awAddr_next;
	logic wHeld_reg, wHeld_next;
	logic [7:0] wData_reg, wData_next;
	logic wLane_reg, wLane_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0] rresp_reg, rresp_next;
	logic wrFire;
	logic wrCtl;
	logic wrCause;
	logic [7:0] ctlRead;
	logic [7:0] causeRead;

	assign s_axi_awready = !awHeld_reg && !bvalid_reg;
	assign s_axi_wready = !wHeld_reg && !bvalid_reg;
	assign s_axi_arready = !rvalid_reg;
	assign wrFire = awHeld_reg && wHeld_reg;
	assign wrCtl = wrFire && wLane_reg && (awAddr_reg == wrsu_pkg::CTL_OFS);
	assign wrCause = wrFire && wLane_reg && (awAddr_reg == wrsu_pkg::CAUSE_OFS);

	// address and data are caught in either order; the write lands once both are held
	always_comb begin
		awHeld_next = awHeld_reg;
		awAddr_next = awAddr_reg;
		wHeld_next = wHeld_reg;
		wData_next = wData_reg;
		wLane_next = wLane_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		if (s_axi_awvalid && s_axi_awready) begin
			awHeld_next = 1'b1;
			awAddr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wHeld_next = 1'b1;
			wData_next = s_axi_wdata[7:0];
			wLane_next = s_axi_wstrb[0];
		end
		if (wrFire) begin
			awHeld_next = 1'b0;
			wHeld_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = wrsu_pkg::isMapped(awAddr_reg) ? wrsu_pkg::RESP_OKAY : wrsu_pkg::RESP_DECERR;
		end else if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
	end

	// reads have no side effects; data is latched at the address handshake
	always_comb begin
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_next = 1'b1;
			rresp_next = wrsu_pkg::isMapped(s_axi_araddr) ? wrsu_pkg::RESP_OKAY : wrsu_pkg::RESP_DECERR;
			if (s_axi_araddr == wrsu_pkg::CTL_OFS) begin
				rdata_next = {24'h000000, ctlRead};
			end else if (s_axi_araddr == wrsu_pkg::CAUSE_OFS) begin
				rdata_next = {24'h000000, causeRead};
			end else begin
				rdata_next = 32'h00000000;
			end
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			awHeld_reg <= 1'b0;
			awAddr_reg <= 8'h00;
			wHeld_reg <= 1'b0;
			wData_reg <= 8'h00;
			wLane_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= 2'h0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= 2'h0;
		end else begin
			awHeld_reg <= awHeld_next;
			awAddr_reg <= awAddr_next;
			wHeld_reg <= wHeld_next;
			wData_reg <= wData_next;
			wLane_reg <= wLane_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	// ----------------------------------------------------------------
	// watchdog control with timed change window
	// ----------------------------------------------------------------
	logic wdEn_reg, wdEn_next;
	logic ce_reg, ce_next;
	logic [2:0] ceCnt_reg, ceCnt_next;
	logic [2:0] presc_reg, presc_next;
	logic wdEnEff;
	logic chipReset;

	assign chipReset = wdt.timeout || pinEdge || supplyEdge;
	assign wdEnEff = wdEn_reg || fuseSafe;

	// the opening write must carry both bits; anything else is an ordinary write
	always_comb begin
		wdEn_next = wdEn_reg;
		ce_next = ce_reg;
		ceCnt_next = ceCnt_reg;
		presc_next = presc_reg;
		if (ce_reg) begin
			ceCnt_next = ceCnt_reg - 3'h1;
			ce_next = (ceCnt_reg != 3'h1);
		end
		if (chipReset) begin
			wdEn_next = 1'b0;
			ce_next = 1'b0;
			presc_next = 3'h0;
		end else if (wrCtl) begin
			if (wData_reg[wrsu_pkg::CE_BIT] && wData_reg[wrsu_pkg::EN_BIT]) begin
				ce_next = 1'b1;
				ceCnt_next = wrsu_pkg::CE_CYCLES;
				wdEn_next = 1'b1;
			end else if (ce_reg) begin
				presc_next = wData_reg[2:0];
				wdEn_next = fuseSafe ? wdEn_reg : wData_reg[wrsu_pkg::EN_BIT];
				ce_next = 1'b0;
			end else if (wData_reg[wrsu_pkg::EN_BIT]) begin
				wdEn_next = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			wdEn_reg <= 1'b0;
			ce_reg <= 1'b0;
			ceCnt_reg <= 3'h0;
			presc_reg <= 3'h0;
		end else begin
			wdEn_reg <= wdEn_next;
			ce_reg <= ce_next;
			ceCnt_reg <= ceCnt_next;
			presc_reg <= presc_next;
		end
	end

	assign ctlRead = {3'h0, ce_reg, wdEnEff, presc_reg};

	// same clock drives both sides, so the signals cross as plain unregistered wires
	assign wdt.kick = kickStrobe;
	assign wdt.clear = !wdEnEff || chipReset;
	assign wdt.enable = wdEnEff;
	assign wdt.presc = presc_reg;

	// ----------------------------------------------------------------
	// reset-cause flags, reset pulse and bandgap enable
	// ----------------------------------------------------------------
	logic [3:0] cause_reg, cause_next;
	logic [3:0] causeSet;
	logic [3:0] causeClr;
	logic pulse_reg, pulse_next;
	logic bandgap_reg, bandgap_next;

	// a source that fires in the same cycle as a clearing write keeps its flag
	always_comb begin
		causeSet = 4'h0;
		causeSet[wrsu_pkg::FLAG_TIMEOUT] = wdt.timeout;
		causeSet[wrsu_pkg::FLAG_SUPPLY] = supplyEdge;
		causeSet[wrsu_pkg::FLAG_PIN] = pinEdge;
		causeClr = wrCause ? ~wData_reg[3:0] : 4'h0;
		cause_next = (cause_reg & ~causeClr) | causeSet;
		pulse_next = wdt.timeout;
		bandgap_next = fuseSupply || comparatorBandgapSelect || adcEnable;
	end

	// only power-up loads the flags, so the power-up flag survives other resets
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			cause_reg <= wrsu_pkg::CAUSE_RESET;
			pulse_reg <= 1'b0;
			bandgap_reg <= 1'b0;
		end else begin
			cause_reg <= cause_next;
			pulse_reg <= pulse_next;
			bandgap_reg <= bandgap_next;
		end
	end

	assign causeRead = {4'h0, cause_reg};
	assign chipResetPulse = pulse_reg;
	assign bandgapPowerOn = bandgap_reg;

	wrsu_osc_tick u_osc (
		.mclk(mclk),
		.rstN(rstN),
		.wdt(wdt.osc)
	);

	wrsu_wdt_count #(.TIMEOUT_BASE(TIMEOUT_BASE)) u_count (
		.mclk(mclk),
		.rstN(rstN),
		.wdt(wdt.counter)
	);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking dc @(posedge mclk); endclocking
	default disable iff (!rstN);

	window_close_a: assert property ($rose(ce_reg) && !wrCtl ##1 (!wrCtl && !chipReset)[*3] |=> !ce_reg)
		else $error("change window open too long");
	presc_guard_a: assert property (wrCtl && !ce_reg && !chipReset |=> $stable(presc_reg))
		else $error("time-out select changed outside window");
	disable_guard_a: assert property (wrCtl && !ce_reg && wdEnEff && !chipReset |=> wdEnEff)
		else $error("watchdog disabled without window");
	safe_level_a: assert property (fuseSafe && $stable(fuseSafe) |-> ctlRead[wrsu_pkg::EN_BIT])
		else $error("enable reads zero at higher level");
	timeout_flag_a: assert property (wdt.timeout |=> cause_reg[wrsu_pkg::FLAG_TIMEOUT] && pulse_reg)
		else $error("time-out did not set flag and pulse");
	pulse_len_a: assert property (pulse_reg |=> !pulse_reg)
		else $error("reset pulse longer than one cycle");
	powerup_keep_a: assert property (cause_reg[wrsu_pkg::FLAG_POWERUP] && !wrCause |=> cause_reg[wrsu_pkg::FLAG_POWERUP])
		else $error("power-up flag lost without write");
	bandgap_on_a: assert property ((comparatorBandgapSelect || adcEnable) |=> bandgapPowerOn)
		else $error("bandgap off while requested");

	open_window_c: cover property ($rose(ce_reg));
	disable_seq_c: cover property (ce_reg && wrCtl && !wData_reg[wrsu_pkg::EN_BIT] && !fuseSafe ##1 !wdEnEff);
	flag_clear_c: cover property (wrCause && !wData_reg[wrsu_pkg::FLAG_POWERUP]);
endmodule
`default_nettype wire

// ---- src/wrsu_pkg.sv ----
// constants, register map and helpers for the watchdog and reset-status unit
// Overview of operation
// - Watchdog counter advances on its own nominal 1 MHz oscillator, not the system clock; here a tick divided down from the 25 MHz system clock.
// - Kick, disabling the watchdog, or any chip reset clears the watchdog counter.
// - Selected time-out elapsing while enabled without a kick issues a chip reset.
// - Fuse unprogrammed: watchdog starts disabled; a plain write of one enables it.
// - Fuse programmed: watchdog always enabled and its enable bit always reads one.
// - Higher level: the second write updates only the time-out select; enable ignored.
// - Change-enable clears itself four clock cycles after being written to one.
// - Writing zero to enable works only while change-enable is one.
// - Time-out select writes are accepted only while change-enable is one.
// - Time-out select code 0 gives 16,384 oscillator cycles, doubling up to 2,097,152.
// - Control bits 7:5 and reset-cause bits 7:4 always read as zero.
// - Reset-cause bit 3 set by watchdog reset, cleared by power-up or writing zero.
// - Reset-cause bit 2 set by supply-drop reset, cleared by power-up or writing zero.
// - Reset-cause bit 1 set by pin reset, cleared by power-up or writing zero.
// - Reset-cause bit 0 set by power-up, cleared only by a software write of zero.
// - Bandgap powered while supply monitor fuse, comparator bandgap select or converter enabled.
// - Watchdog time-out gives an internal reset pulse of one system clock cycle.
`default_nettype none
package wrsu_pkg;
	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 25_000_000;
	localparam int OSC_HZ = 1_000_000;
	localparam int OSC_DIV = CLK_HZ / OSC_HZ;
	localparam logic [4:0] OSC_DIV_LAST = 5'(OSC_DIV - 1);
	localparam int TIMEOUT_BASE_DEF = 16384;
	localparam int CNT_W = 22;
	localparam logic [2:0] CE_CYCLES = 3'h4;
	// ----------------------------------------------------------------
	// register map and fields
	// ----------------------------------------------------------------
	localparam logic [7:0] CTL_OFS = 8'h00;
	localparam logic [7:0] CAUSE_OFS = 8'h04;
	localparam int CE_BIT = 4;
	localparam int EN_BIT = 3;
	localparam int FLAG_TIMEOUT = 3;
	localparam int FLAG_SUPPLY = 2;
	localparam int FLAG_PIN = 1;
	localparam int FLAG_POWERUP = 0;
	localparam logic [3:0] CAUSE_RESET = 4'h1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// time-out length in oscillator cycles for a select code
	function automatic logic [CNT_W-1:0] timeoutLimit(input logic [2:0] sel, input int base);
		timeoutLimit = CNT_W'(base) << sel;
	endfunction

	// address decode shared by the read and write paths
	function automatic logic isMapped(input logic [7:0] addr);
		isMapped = (addr == CTL_OFS) || (addr == CAUSE_OFS);
	endfunction
endpackage
`default_nettype wire

// ---- src/wrsu_wdt_if.sv ----
// signals between the register core, the oscillator tick and the watchdog counter
`timescale 1ns/100ps
`default_nettype none
interface wrsu_wdt_if;
	logic oscTick;
	logic kick;
	logic clear;
	logic enable;
	logic [2:0] presc;
	logic timeout;
	modport core (output kick, output clear, output enable, output presc, input timeout, input oscTick);
	modport osc (output oscTick);
	modport counter (input oscTick, input kick, input clear, input enable, input presc, output timeout);
endinterface
`default_nettype wire

// ---- src/wrsu_osc_tick.sv ----
// watchdog oscillator stand-in: one-cycle tick at the oscillator rate
`timescale 1ns/100ps
`default_nettype none
module wrsu_osc_tick (
	input wire logic mclk,
	input wire logic rstN,
	wrsu_wdt_if.osc wdt
);
	logic [4:0] div_reg;
	logic [4:0] div_next;
	logic tick_reg;
	logic tick_next;

	// divide the system clock down to the oscillator rate
	always_comb begin
		tick_next = (div_reg == wrsu_pkg::OSC_DIV_LAST);
		div_next = tick_next ? 5'h00 : div_reg + 5'h01;
	end

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			div_reg <= 5'h00;
			tick_reg <= 1'b0;
		end else begin
			div_reg <= div_next;
			tick_reg <= tick_next;
		end
	end

	assign wdt.oscTick = tick_reg;
endmodule
`default_nettype wire

// ---- src/wrsu_wdt_count.sv ----
// watchdog counter: counts oscillator ticks, flags the selected time-out
`timescale 1ns/100ps
`default_nettype none
module wrsu_wdt_count #(
	parameter int TIMEOUT_BASE = wrsu_pkg::TIMEOUT_BASE_DEF
) (
	input wire logic mclk,
	input wire logic rstN,
	wrsu_wdt_if.counter wdt
);
	logic [wrsu_pkg::CNT_W-1:0] cnt_reg;
	logic [wrsu_pkg::CNT_W-1:0] cnt_next;
	logic [wrsu_pkg::CNT_W-1:0] limit;
	logic timeout_reg;
	logic timeout_next;

	// kick and clear win over counting, so a late kick still saves the chip
	always_comb begin
		limit = wrsu_pkg::timeoutLimit(wdt.presc, TIMEOUT_BASE);
		cnt_next = cnt_reg;
		timeout_next = 1'b0;
		if (wdt.kick || wdt.clear) begin
			cnt_next = '0;
		end else if (wdt.enable && wdt.oscTick) begin
			if (cnt_reg >= limit - wrsu_pkg::CNT_W'(1)) begin
				cnt_next = '0;
				timeout_next = 1'b1;
			end else begin
				cnt_next = cnt_reg + wrsu_pkg::CNT_W'(1);
			end
		end
	end

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			cnt_reg <= '0;
			timeout_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			timeout_reg <= timeout_next;
		end
	end

	assign wdt.timeout = timeout_reg;

	timeout_cause_a: assert property (@(posedge mclk) disable iff (!rstN)
		$rose(timeout_reg) |-> $past(wdt.enable) && $past(wdt.oscTick)
			&& $past(cnt_reg) == wrsu_pkg::timeoutLimit($past(wdt.presc), TIMEOUT_BASE) - wrsu_pkg::CNT_W'(1))
		else $error("time-out without a full count");
	count_clear_a: assert property (@(posedge mclk) disable iff (!rstN)
		(wdt.kick || wdt.clear) |=> cnt_reg == '0 && !timeout_reg)
		else $error("counter not cleared by kick or clear");
	timeout_cov_c: cover property (@(posedge mclk) disable iff (!rstN) timeout_reg);
endmodule
`default_nettype wire

// ---- dv/tb_watchdog_reset_status_unit.sv ----
// self-checking bench for the watchdog and reset-status unit
`timescale 1ns/100ps
`default_nettype none
module tb_watchdog_reset_status_unit;
	// short base keeps each time-out a few hundred clocks
	localparam int BASE = 4;
	localparam int TICK = 25;
	localparam int LIMIT = 20000;
	localparam logic [7:0] CTL = wrsu_pkg::CTL_OFS;
	localparam logic [7:0] CAUSE = wrsu_pkg::CAUSE_OFS;
	logic mclk, reset_n, awValid, awReady, wValid, wReady, bValid, bReady, arValid, arReady, rValid, rReady;
	logic [7:0] awAddr, arAddr;
	logic [31:0] wData, rData;
	logic [3:0] wStrb;
	logic [1:0] bResp, rResp, resp;
	logic kickStrobe, safetyLevelFuse, supplyMonitorFuse, comparatorBandgapSelect, adcEnable;
	logic pinResetIn, supplyDropIn, chipResetPulse, bandgapPowerOn;
	int mismatches = 0, numChecks = 0, cycles = 0, pulseCount = 0;

	wrsu_top #(.TIMEOUT_BASE(BASE)) DUT (.mclk(mclk), .reset_n(reset_n), .s_axi_awaddr(awAddr),
		.s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
		.s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
		.s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
		.s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
		.kickStrobe(kickStrobe), .safetyLevelFuse(safetyLevelFuse), .supplyMonitorFuse(supplyMonitorFuse),
		.comparatorBandgapSelect(comparatorBandgapSelect), .adcEnable(adcEnable), .pinResetIn(pinResetIn),
		.supplyDropIn(supplyDropIn), .chipResetPulse(chipResetPulse), .bandgapPowerOn(bandgapPowerOn));

	// ----------------------------------------------------------------
	// clock, hang guard and reports
	// ----------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// inputs only move at rising edges, so the falling edge sees settled values
	always @(negedge mclk) begin
		if (chipResetPulse === 1'b1) pulseCount++;
	end
	always @(posedge mclk) begin
		cycles++;
		if (cycles == LIMIT) begin
			mismatches++;
			endSim();
		end
	end
	task automatic endSim();
		$display("checks %0d mismatches %0d", numChecks, mismatches);
		if (mismatches == 0 && numChecks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic checkWord(input string name, input logic [31:0] exp, input logic [31:0] got);
		numChecks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic checkRange(input string name, input int lo, input int hi, input int got);
		numChecks++;
		if (got < lo || got > hi) begin
			mismatches++;
			$display("unexpected %s expected %0d..%0d seen %0d", name, lo, hi, got);
		end
	endtask

	// ----------------------------------------------------------------
	// bus cycles: entered just after a rising edge, leave on one
	// ----------------------------------------------------------------
	task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw, w, awDone, wDone, b;
		awAddr <= a;
		wData <= d;
		awValid <= 1'b1;
		wValid <= 1'b1;
		awDone = 1'b0;
		wDone = 1'b0;
		b = 1'b0;
		while (!(awDone && wDone)) begin
			@(negedge mclk);
			aw = awReady && !awDone;
			w = wReady && !wDone;
			@(posedge mclk);
			if (aw) begin
				awValid <= 1'b0;
				awDone = 1'b1;
			end
			if (w) begin
				wValid <= 1'b0;
				wDone = 1'b1;
			end
		end
		while (!b) begin
			@(negedge mclk);
			b = bValid;
			r = bResp;
			@(posedge mclk);
		end
	endtask
	task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar, v;
		arAddr <= a;
		arValid <= 1'b1;
		ar = 1'b0;
		v = 1'b0;
		while (!ar) begin
			@(negedge mclk);
			ar = arReady;
			@(posedge mclk);
		end
		arValid <= 1'b0;
		while (!v) begin
			@(negedge mclk);
			v = rValid;
			d = rData;
			r = rResp;
			@(posedge mclk);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		axiWrite(a, {24'h000000, d}, resp);
		checkWord("bresp", {30'h0, wrsu_pkg::RESP_OKAY}, {30'h0, resp});
	endtask
	task automatic expectReg(input logic [7:0] a, input logic [7:0] exp);
		logic [31:0] d;
		axiRead(a, d, resp);
		checkWord("rdata", {24'h000000, exp}, d);
		checkWord("rresp", {30'h0, wrsu_pkg::RESP_OKAY}, {30'h0, resp});
	endtask
	task automatic powerUp();
		reset_n <= 1'b0;
		repeat (10) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (3) @(posedge mclk);
	endtask
	task automatic kick();
		kickStrobe <= 1'b1;
		@(posedge mclk);
		kickStrobe <= 1'b0;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic testResetAndMap();
		logic [31:0] d;
		expectReg(CTL, 8'h00);
		expectReg(CAUSE, 8'h01);
		// a write with byte lane 0 switched off must leave the flags alone
		wStrb <= 4'h0;
		wr(CAUSE, 8'h00);
		wStrb <= 4'hF;
		expectReg(CAUSE, 8'h01);
		axiRead(8'h08, d, resp);
		checkWord("rresp", {30'h0, wrsu_pkg::RESP_DECERR}, {30'h0, resp});
		axiWrite(8'h0C, 32'h000000FF, resp);
		checkWord("bresp", {30'h0, wrsu_pkg::RESP_DECERR}, {30'h0, resp});
	endtask
	// pin and supply events set their flags, power-up flag survives them
	task automatic testFlags();
		pinResetIn <= 1'b1;
		repeat (4) @(posedge mclk);
		pinResetIn <= 1'b0;
		repeat (4) @(posedge mclk);
		expectReg(CAUSE, 8'h03);
		supplyDropIn <= 1'b1;
		repeat (4) @(posedge mclk);
		supplyDropIn <= 1'b0;
		repeat (4) @(posedge mclk);
		expectReg(CAUSE, 8'h07);
		wr(CAUSE, 8'hFF);
		expectReg(CAUSE, 8'h07);
		wr(CAUSE, 8'h00);
		expectReg(CAUSE, 8'h00);
	endtask
	// lower level: plain enable, refused disable and select, timed sequence
	task automatic testLowerLevel();
		wr(CTL, 8'h08);
		expectReg(CTL, 8'h08);
		wr(CTL, 8'h00);
		wr(CTL, 8'hE5);
		expectReg(CTL, 8'h08);
		wr(CTL, 8'h18);
		repeat (6) @(posedge mclk);
		wr(CTL, 8'h02);
		expectReg(CTL, 8'h08);
		wr(CTL, 8'h18);
		wr(CTL, 8'h02);
		expectReg(CTL, 8'h02);
	endtask
	// kicks hold the time-out off; a disabled watchdog never fires
	task automatic testKickAndDisable();
		int p;
		wr(CTL, 8'h08);
		p = pulseCount;
		repeat (10) begin
			kick();
			repeat (50) @(posedge mclk);
		end
		wr(CTL, 8'h18);
		wr(CTL, 8'h00);
		repeat (300) @(posedge mclk);
		checkRange("pulses", p, p, pulseCount);
	endtask
	// select codes 0 to 3: length of the time-out, pulse width, flag and re-init
	task automatic testTimeouts();
		int n, w, t;
		for (int s = 0; s < 4; s++) begin
			wr(CTL, 8'h08);
			wr(CTL, 8'h18);
			wr(CTL, 8'h08 | 8'(s));
			kick();
			t = (BASE << s) * TICK;
			n = 0;
			w = 0;
			do begin
				@(negedge mclk);
				n++;
			end while (chipResetPulse !== 1'b1 && n < 3000);
			while (chipResetPulse === 1'b1 && w < 10) begin
				w++;
				@(negedge mclk);
			end
			@(posedge mclk);
			checkRange("timeout cycles", t - TICK, t + 2 * TICK, n);
			checkRange("pulse width", 1, 1, w);
			expectReg(CAUSE, 8'h08);
			expectReg(CTL, 8'h00);
		end
		powerUp();
		expectReg(CAUSE, 8'h01);
	endtask
	// higher level: enable stuck at one, only the select moves
	task automatic testHigherLevel();
		safetyLevelFuse <= 1'b1;
		powerUp();
		kick();
		expectReg(CTL, 8'h08);
		wr(CTL, 8'h00);
		wr(CTL, 8'h05);
		expectReg(CTL, 8'h08);
		wr(CTL, 8'h18);
		wr(CTL, 8'h03);
		expectReg(CTL, 8'h0B);
		safetyLevelFuse <= 1'b0;
		powerUp();
	endtask
	task automatic testBandgap();
		logic [2:0] c;
		for (int i = 0; i < 8; i++) begin
			c = 3'(i);
			supplyMonitorFuse <= c[0];
			comparatorBandgapSelect <= c[1];
			adcEnable <= c[2];
			// give the fuse synchroniser and output register time to settle before checking
			repeat (6) @(posedge mclk);
			@(negedge mclk);
			checkWord("bandgap", {31'h0, |c}, {31'h0, bandgapPowerOn});
			@(posedge mclk);
		end
	endtask

	initial begin
		reset_n = 1'b0;
		{awValid, wValid, arValid, kickStrobe, safetyLevelFuse, supplyMonitorFuse} = 6'h00;
		{comparatorBandgapSelect, adcEnable, pinResetIn, supplyDropIn} = 4'h0;
		awAddr = 8'h00;
		arAddr = 8'h00;
		wData = 32'h00000000;
		wStrb = 4'hF;
		// responses are always welcome, so both ready lines stay high
		bReady = 1'b1;
		rReady = 1'b1;
		@(posedge mclk);
		powerUp();
		testResetAndMap();
		testFlags();
		testLowerLevel();
		testKickAndDisable();
		testTimeouts();
		testHigherLevel();
		testBandgap();
		endSim();
	end
endmodule
`default_nettype wire
